/* File: hdl/tbhc_pkg.sv */
// constants and register layout for the timebase host control block
package tbhc_pkg;
  // ****************************************************************
  // register byte offsets inside the 512-byte space
  // ****************************************************************
  localparam int unsigned tbhc_space_bytes = 512;
  localparam logic [8:0] tbhc_off_mcfg = 9'h000;
  localparam logic [8:0] tbhc_off_icfg = 9'h008;
  localparam logic [8:0] tbhc_off_ien = 9'h00C;
  localparam logic [8:0] tbhc_off_fsel0 = 9'h010;
  localparam logic [8:0] tbhc_off_flags = 9'h020;
  localparam logic [8:0] tbhc_off_tb1 = 9'h024;
  localparam logic [8:0] tbhc_off_tb2 = 9'h028;
  localparam int unsigned tbhc_fsel_regs = 4;
  // ****************************************************************
  // module configuration fields
  // ****************************************************************
  localparam int unsigned tbhc_b_stop = 15;
  localparam int unsigned tbhc_b_tb1div = 13;
  localparam int unsigned tbhc_b_tb2div = 11;
  localparam int unsigned tbhc_b_stf = 10;
  localparam int unsigned tbhc_b_timebase_two_clock_gate = 9;
  localparam int unsigned tbhc_b_emu = 8;
  localparam int unsigned tbhc_b_prescaler_clock_select = 7;
  localparam int unsigned tbhc_lvl_w = 3;
  // ****************************************************************
  // reset values and dividers
  // ****************************************************************
  localparam logic [15:0] tbhc_rst_16 = 16'h0000;
  localparam logic [31:0] tbhc_zero32 = 32'h0000_0000;
  localparam logic [3:0] tbhc_be_full = 4'hF;
  localparam logic [4:0] tbhc_div32_end = 5'h1F;
  localparam logic [1:0] tbhc_div4_end = 2'h3;
  localparam logic [2:0] tbhc_sysclk_div_eight_end = 3'h7;
  localparam logic [2:0] tbhc_filt_full = 3'h7;
  localparam logic [2:0] tbhc_filt_none = 3'h0;
endpackage : tbhc_pkg

/* File: hdl/tbhc_top.sv */
// timebase prescalers, emulation/stop control and channel irq registers
`timescale 1ns/10ps
// Summary of operation
// - full-word access only; the flag register also takes byte writes.
// - 512-byte space decoded; unused locations read as zero.
// - timebase one source is clock over 32, or over 4 when selected.
// - timebase one divider further divides by 1, 2, 4 or 8.
// - gate mode: pin high lets clock over 8 count, low holds.
// - clock mode: synchronized, filtered rising pin edges clock timebase two.
// - timebase two divider gives 8, 16, 32 or 64 in gate mode.
// - emulation bit: engine fetches from standby ram, host blocked.
// - emulation bit takes only the first write after reset.
// - stop bit halts engine, gates clocks, freezes both timebases.
// - read-only stopped flag reports completed shutdown.
// - enable register, one bit per channel, allows irq requests.
// - irq request needs flag, enable bit and nonzero level.
// - flag cleared only by read of flags then writing zero.
// - each channel has a 4-bit function select of 16 choices.
module tbhc_top
  import tbhc_pkg::*;
#(
  parameter int unsigned num_channels = 16
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [6:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic timebase_two_pin,
  input wire logic [15:0] chan_flag_set,
  output logic [15:0] timebase_one,
  output logic [15:0] timebase_two,
  output logic [63:0] chan_function,
  output logic [15:0] channel_irq_enable,
  output logic [15:0] channel_irq_flags,
  output logic [2:0] irq_level_field,
  output logic irq_request,
  output logic engine_halt,
  output logic emu_fetch_from_ram,
  output logic ram_host_block
);
  // ****************************************************************
  // elaboration check
  // ****************************************************************
  if (num_channels != 16) begin : g_chk
    $error("tbhc_top serves exactly 16 channels");
  end

  // ****************************************************************
  // state record
  // ****************************************************************
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic stop;
    logic stopped_flag;
    logic emulation_bit;
    logic emu_locked;
    logic prescaler_clock_select;
    logic timebase_two_clock_gate;
    logic [1:0] tb1div;
    logic [1:0] tb2div;
    logic [2:0] level;
    logic [15:0] ien;
    logic [15:0] flags;
    logic [15:0] armed;
    logic [63:0] fsel;
    logic [4:0] pre;
    logic [2:0] div1;
    logic [2:0] div2;
    logic [15:0] tb1;
    logic [15:0] tb2;
    logic sync1;
    logic sync2;
    logic [2:0] filt;
    logic pin_f;
  } tbhc_state_t;

  tbhc_state_t s_q;
  tbhc_state_t s_d;

  // ****************************************************************
  // decode helpers
  // ****************************************************************
  // mask for the 1/2/4/8 divider: counts until low bits all ones
  function automatic logic [2:0] tbhc_div_mask(input logic [1:0] sel);
    unique case (sel)
      2'h0: tbhc_div_mask = 3'h0;
      2'h1: tbhc_div_mask = 3'h1;
      2'h2: tbhc_div_mask = 3'h3;
      2'h3: tbhc_div_mask = 3'h7;
    endcase
  endfunction

  // shared by read and write so both decode the same four words
  function automatic logic tbhc_fsel_hit(input logic [8:0] addr,
      input int unsigned idx);
    tbhc_fsel_hit = (addr == tbhc_off_fsel0 + 9'(4 * idx));
  endfunction

  logic [8:0] byte_addr;
  logic full_word;
  logic do_write;
  logic do_read;
  logic [15:0] mcfg_view;
  logic tick1;
  logic tick2;
  logic pin_rise;
  logic [15:0] wr_flags;
  logic [15:0] flag_keep;

  assign byte_addr = {avs_address, 2'b00};
  // ****************************************************************
  // bus handshake: one wait cycle, then the answer
  // ****************************************************************
  assign avs_waitrequest = (avs_read | avs_write) & ~s_q.ack;
  assign do_write = avs_write & s_q.ack;
  assign do_read = avs_read & s_q.ack;
  assign full_word = (avs_byteenable == tbhc_be_full);

  // ****************************************************************
  // configuration view
  // ****************************************************************
  always_comb begin
    mcfg_view = tbhc_rst_16;
    mcfg_view[tbhc_b_stop] = s_q.stop;
    mcfg_view[tbhc_b_tb1div +: 2] = s_q.tb1div;
    mcfg_view[tbhc_b_tb2div +: 2] = s_q.tb2div;
    mcfg_view[tbhc_b_stf] = s_q.stopped_flag;
    mcfg_view[tbhc_b_timebase_two_clock_gate] = s_q.timebase_two_clock_gate;
    mcfg_view[tbhc_b_emu] = s_q.emulation_bit;
    mcfg_view[tbhc_b_prescaler_clock_select] = s_q.prescaler_clock_select;
  end

  // ****************************************************************
  // prescaler ticks
  // ****************************************************************
  // source divided by 4 or 32
  assign tick1 = s_q.prescaler_clock_select ? (s_q.pre[1:0] == tbhc_div4_end)
                          : (s_q.pre == tbhc_div32_end);
  // filtered rising edge of the pin
  assign pin_rise = (s_q.filt == tbhc_filt_full) & ~s_q.pin_f;
  // pin gates the clock over 8
  assign tick2 = s_q.timebase_two_clock_gate ? ((s_q.pre[2:0] == tbhc_sysclk_div_eight_end) & s_q.sync2)
                          : pin_rise;

  // ****************************************************************
  // flag register byte lanes
  // ****************************************************************
  // byte lanes for the flag register; other registers need full words
  always_comb begin
    wr_flags = s_q.flags;
    if (avs_byteenable[0]) begin
      wr_flags[7:0] = avs_writedata[7:0];
    end
    if (avs_byteenable[1]) begin
      wr_flags[15:8] = avs_writedata[15:8];
    end
  end

  always_comb begin
    s_d = s_q;
    s_d.ack = (avs_read | avs_write) & ~s_q.ack;

    // ****************************************************************
    // pin synchroniser and filter
    // ****************************************************************
    // pin synchroniser, first stage read only by the second
    s_d.sync1 = timebase_two_pin;
    s_d.sync2 = s_q.sync1;
    // digital filter needs three agreeing samples
    s_d.filt = {s_q.filt[1:0], s_q.sync2};
    if (s_q.filt == tbhc_filt_full) begin
      s_d.pin_f = 1'b1;
    end else if (s_q.filt == tbhc_filt_none) begin
      s_d.pin_f = 1'b0;
    end

    // ****************************************************************
    // timebase counters
    // ****************************************************************
    // clocks gated while stopped, counters freeze
    if (!s_q.stop) begin
      s_d.pre = s_q.pre + 5'h01;
      if (tick1) begin
        // divide by 1, 2, 4 or 8
        if ((s_q.div1 & tbhc_div_mask(s_q.tb1div)) ==
            tbhc_div_mask(s_q.tb1div)) begin
          s_d.div1 = 3'h0;
          s_d.tb1 = s_q.tb1 + 16'h0001;
        end else begin
          s_d.div1 = s_q.div1 + 3'h1;
        end
      end
      if (tick2) begin
        // divide by 1, 2, 4 or 8 after the gate
        if ((s_q.div2 & tbhc_div_mask(s_q.tb2div)) ==
            tbhc_div_mask(s_q.tb2div)) begin
          s_d.div2 = 3'h0;
          s_d.tb2 = s_q.tb2 + 16'h0001;
        end else begin
          s_d.div2 = s_q.div2 + 3'h1;
        end
      end
    end
    // flag follows one cycle after stop takes effect
    // and drops once stop is cleared
    s_d.stopped_flag = s_q.stop;

    // ****************************************************************
    // register writes
    // ****************************************************************
    flag_keep = 16'hFFFF;
    if (do_write && full_word) begin
      unique case (byte_addr)
        tbhc_off_mcfg: begin
          s_d.stop = avs_writedata[tbhc_b_stop];
          s_d.tb1div = avs_writedata[tbhc_b_tb1div +: 2];
          s_d.tb2div = avs_writedata[tbhc_b_tb2div +: 2];
          s_d.timebase_two_clock_gate = avs_writedata[tbhc_b_timebase_two_clock_gate];
          s_d.prescaler_clock_select = avs_writedata[tbhc_b_prescaler_clock_select];
          if (!s_q.emu_locked) begin
            s_d.emulation_bit = avs_writedata[tbhc_b_emu];
            s_d.emu_locked = 1'b1;
          end
        end
        tbhc_off_icfg: s_d.level = avs_writedata[tbhc_lvl_w-1:0];
        tbhc_off_ien: s_d.ien = avs_writedata[15:0];
        default: begin
          for (int i = 0; i < tbhc_fsel_regs; i++) begin
            if (tbhc_fsel_hit(byte_addr, i)) begin
              s_d.fsel[16*i +: 16] = avs_writedata[15:0];
            end
          end
        end
      endcase
    end
    // zero written only clears a bit seen set by a read
    if (do_write && byte_addr == tbhc_off_flags) begin
      flag_keep = wr_flags | ~s_q.armed;
      s_d.armed = s_q.armed & wr_flags;
    end
    // hardware set wins over a clear in the same cycle
    s_d.flags = (s_q.flags & flag_keep) | chan_flag_set;

    // ****************************************************************
    // register reads, prepared during the wait cycle
    // ****************************************************************
    if ((avs_read | avs_write) && !s_q.ack) begin
      s_d.rdata = tbhc_zero32;
      // anything not listed reads as zero
      unique case (byte_addr)
        tbhc_off_mcfg: s_d.rdata[15:0] = mcfg_view;
        tbhc_off_icfg: s_d.rdata[tbhc_lvl_w-1:0] = s_q.level;
        tbhc_off_ien: s_d.rdata[15:0] = s_q.ien;
        tbhc_off_flags: s_d.rdata[15:0] = s_q.flags;
        tbhc_off_tb1: s_d.rdata[15:0] = s_q.tb1;
        tbhc_off_tb2: s_d.rdata[15:0] = s_q.tb2;
        default: begin
          for (int i = 0; i < tbhc_fsel_regs; i++) begin
            if (tbhc_fsel_hit(byte_addr, i)) begin
              s_d.rdata[15:0] = s_q.fsel[16*i +: 16];
            end
          end
        end
      endcase
    end
    // a flags read arms the bits it returned
    if (do_read && byte_addr == tbhc_off_flags) begin
      s_d.armed = s_q.armed | s_q.rdata[15:0];
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge clock) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign avs_readdata = s_q.rdata;
  assign timebase_one = s_q.tb1;
  assign timebase_two = s_q.tb2;
  assign chan_function = s_q.fsel;
  assign channel_irq_enable = s_q.ien;
  assign channel_irq_flags = s_q.flags;
  assign irq_level_field = s_q.level;
  // request needs flag, enable and nonzero level
  assign irq_request = (|(s_q.flags & s_q.ien)) & (|s_q.level);
  assign engine_halt = s_q.stop;
  // emulation redirects fetch and blocks host ram access
  assign emu_fetch_from_ram = s_q.emulation_bit;
  assign ram_host_block = s_q.emulation_bit;
endmodule // tbhc_top

/* File: bench/tbhc_chk.sv */
// assertion checker on the ports of the timebase host control block
`timescale 1ns/10ps
module tbhc_chk
  import tbhc_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic [6:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [15:0] chan_flag_set,
  input wire logic [15:0] timebase_one,
  input wire logic [15:0] timebase_two,
  input wire logic [15:0] channel_irq_enable,
  input wire logic [15:0] channel_irq_flags,
  input wire logic [2:0] irq_level_field,
  input wire logic irq_request,
  input wire logic engine_halt,
  input wire logic emu_fetch_from_ram,
  input wire logic ram_host_block
);
  // ****************************************************************
  // properties
  // ****************************************************************
  logic lk_q;
  wire logic wdone = avs_write && !avs_waitrequest;
  wire logic mwr = wdone && avs_address == 7'h00;
  wire logic cfg_first = mwr && avs_byteenable == tbhc_be_full && !lk_q;
  // lock follows the first full-word config write, whatever its value
  always_ff @(posedge clock) begin
    lk_q <= resetn && (lk_q || (mwr && avs_byteenable == tbhc_be_full));
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence s_req; $rose(avs_read || avs_write); endsequence
  sequence s_ans; avs_waitrequest ##1 !avs_waitrequest; endsequence
  a_one_wait: assert property (s_req |-> s_ans)
    else $error("bus request not answered after one wait");
  a_unmapped_zero: assert property (avs_read && !avs_waitrequest &&
    (avs_address == 7'h01 || avs_address > 7'h0A) |-> avs_readdata == '0)
    else $error("unmapped read not zero");
  a_irq_gate: assert property (irq_request ==
    ((|(channel_irq_flags & channel_irq_enable)) && |irq_level_field))
    else $error("irq request does not match flags, enables, level");
  a_flag_set: assert property (|chan_flag_set |=>
    (channel_irq_flags & $past(chan_flag_set)) == $past(chan_flag_set))
    else $error("flag not set by microcode pulse");
  a_flag_hold: assert property (!wdone |=>
    ($past(channel_irq_flags) & ~channel_irq_flags) == '0)
    else $error("flag cleared without host write");
  a_stop_freeze: assert property (engine_halt && $past(engine_halt)
    |-> $stable(timebase_one) && $stable(timebase_two))
    else $error("timebase moved while stopped");
  a_emu_block: assert property (emu_fetch_from_ram == ram_host_block)
    else $error("ram fetch and host block disagree");
  a_emu_lock: assert property (lk_q && $past(lk_q)
    |-> $stable(emu_fetch_from_ram))
    else $error("emulation bit changed after lock");
  a_emu_first: assert property ($changed(emu_fetch_from_ram)
    |-> $past(cfg_first))
    else $error("emulation bit changed outside first config write");
endmodule // tbhc_chk

/* File: bench/tbhc_host.sv */
// host processor model mastering the register bus
`timescale 1ns/10ps
module tbhc_host (
  input wire logic clock,
  input wire logic avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  output logic [6:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable
);
  // ****************************************************************
  // bus cycle
  // ****************************************************************
  int hangs = 0;
  initial begin
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    avs_byteenable = 4'hF;
  end
  // lanes chosen by caller
  // request held until waitrequest low; a gap edge keeps drivers clean
  task automatic xfer(input logic w, input logic [6:0] a,
      input logic [31:0] d, input logic [3:0] be, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_read <= !w;
    avs_write <= w;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50) begin
      hangs++;
      tbhc_top_tb.wrap_up();
    end
  endtask
endmodule // tbhc_host

/* File: bench/tbhc_top_tb.sv */
// self-checking testbench for the timebase host control block
`timescale 1ns/10ps
module tbhc_top_tb;
  import tbhc_pkg::*;
  // ****************************************************************
  // harness
  // ****************************************************************
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic timebase_two_pin = 1'b0;
  logic [15:0] chan_flag_set = '0;
  logic [6:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest, irq_request, engine_halt;
  logic emu_fetch_from_ram, ram_host_block;
  logic [31:0] avs_writedata, avs_readdata, rdv;
  logic [3:0] avs_byteenable;
  logic [15:0] timebase_one, timebase_two, channel_irq_enable;
  logic [15:0] channel_irq_flags;
  logic [63:0] chan_function;
  logic [2:0] irq_level_field;
  int miscompares = 0;
  int n_compared = 0;
  tbhc_top u_tbhc_top (.clock, .resetn, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .timebase_two_pin, .chan_flag_set, .timebase_one,
    .timebase_two, .chan_function, .channel_irq_enable, .channel_irq_flags,
    .irq_level_field, .irq_request, .engine_halt, .emu_fetch_from_ram,
    .ram_host_block);
  tbhc_host u_host (.clock, .avs_waitrequest, .avs_readdata, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable);
  always #12.5 clock = ~clock;
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] d,
      input logic [3:0] be = 4'hF);
    u_host.xfer(1'b1, a, {16'h0000, d}, be, rdv);
    @(posedge clock);
  endtask
  task automatic rdc(input logic [6:0] a, input logic [31:0] exp);
    u_host.xfer(1'b0, a, '0, 4'hF, rdv);
    cmp(rdv, exp);
  endtask
  // delta over whole periods is phase independent
  task automatic rate(input logic two, input int cyc, input logic [15:0] e);
    logic [15:0] s;
    repeat (8) @(posedge clock);
    s = two ? timebase_two : timebase_one;
    repeat (cyc) @(posedge clock);
    s = (two ? timebase_two : timebase_one) - s;
    cmp({16'h0000, s}, {16'h0000, e});
  endtask
  task automatic t_regs;
    rdc(7'h00, '0);
    rdc(7'h01, '0);
    rdc(7'h7F, '0);
    wr(7'h03, 16'h00FF, 4'h3);
    rdc(7'h03, '0);
    wr(7'h03, 16'h8001);
    rdc(7'h03, 32'h0000_8001);
    wr(7'h04, 16'hA5C3);
    wr(7'h07, 16'h5E0F);
    cmp({chan_function[63:48], chan_function[15:0]}, 32'h5E0F_A5C3);
  endtask
  task automatic t_irq;
    @(posedge clock) chan_flag_set <= 16'h0001;
    @(posedge clock) chan_flag_set <= '0;
    @(posedge clock);
    cmp(32'(irq_request), '0);
    wr(7'h02, 16'h0003);
    cmp(32'(irq_request), 32'(1'b1));
    wr(7'h03, 16'h0000);
    cmp(32'(irq_request), '0);
    wr(7'h08, 16'h0000, 4'h1);
    rdc(7'h08, 32'h0000_0001);
    wr(7'h08, 16'h0000, 4'h1);
    rdc(7'h08, '0);
  endtask
  task automatic t_tb;
    logic [15:0] s;
    wr(7'h00, 16'h0180);
    cmp(32'({emu_fetch_from_ram, ram_host_block}), 32'(2'b11));
    rate(1'b0, 40, 16'h000A);
    wr(7'h00, 16'h6000);
    rdc(7'h00, 32'h0000_6100);
    rate(1'b0, 512, 16'h0002);
    wr(7'h00, 16'h0A80);
    timebase_two_pin <= 1'b1;
    rate(1'b1, 160, 16'h000A);
    timebase_two_pin <= 1'b0;
    rate(1'b1, 64, 16'h0000);
    wr(7'h00, 16'h0080);
    s = timebase_two;
    timebase_two_pin <= 1'b1;
    @(posedge clock) timebase_two_pin <= 1'b0;
    repeat (5) begin
      repeat (8) @(posedge clock);
      timebase_two_pin <= 1'b1;
      repeat (8) @(posedge clock);
      timebase_two_pin <= 1'b0;
    end
    repeat (8) @(posedge clock);
    s = timebase_two - s;
    cmp({16'h0000, s}, 32'h0000_0005);
  endtask
  task automatic t_stop;
    wr(7'h00, 16'h8080);
    rdc(7'h00, 32'h0000_8580);
    cmp(32'(engine_halt), 32'(1'b1));
    rate(1'b0, 40, 16'h0000);
    wr(7'h00, 16'h0080);
    rdc(7'h00, 32'h0000_0180);
    rate(1'b0, 40, 16'h000A);
  endtask
  task automatic t_div;
    timebase_two_pin <= 1'b1;
    wr(7'h00, 16'h2080);
    rate(1'b0, 80, 16'h000A);
    wr(7'h00, 16'h5280);
    rate(1'b0, 160, 16'h000A);
    rate(1'b1, 320, 16'h000A);
    wr(7'h00, 16'h1A80);
    rate(1'b1, 640, 16'h000A);
    timebase_two_pin <= 1'b0;
  endtask
  task automatic wrap_up;
    miscompares += u_host.hangs;
    $display("compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    t_regs();
    t_irq();
    t_tb();
    t_stop();
    t_div();
    wrap_up();
  end
endmodule // tbhc_top_tb
bind tbhc_top tbhc_chk u_chk (.clock, .resetn, .avs_address, .avs_read,
  .avs_write, .avs_byteenable, .avs_readdata, .avs_waitrequest,
  .chan_flag_set, .timebase_one, .timebase_two, .channel_irq_enable,
  .channel_irq_flags, .irq_level_field, .irq_request, .engine_halt,
  .emu_fetch_from_ram, .ram_host_block);
